//--- core/test_capture_map.svh
// Offsets, field positions, reset values and counts of the test capture block
`ifndef TEST_CAPTURE_MAP_SVH
`define TEST_CAPTURE_MAP_SVH

// Host data bus and register widths
`define TC_BUS_W            10
`define TC_REG_W            8
`define TC_PTR_W            8

// Register offsets selected through the address pointer
`define TC_OFS_PIXEL_MASK   8'h04
`define TC_OFS_IN_CAP       8'h05
`define TC_OFS_CMD_TWO      8'h06
`define TC_OFS_CMD_THREE    8'h07
`define TC_OFS_OUT_CAP      8'h08
`define TC_OFS_STATUS_CAP   8'h09

// Field positions in command_two and command_three
`define TC_EDGE_SEL_BIT     0
`define TC_RES8_BIT         1
`define TC_BUS8_BIT         1

// Field positions in the status capture byte
`define TC_STAT_SYNC_BIT    0
`define TC_STAT_BLANK_BIT   1
`define TC_STAT_PLL_BIT     2

// Reset values
`define TC_RST_REG          8'h00
`define TC_RST_PTR          8'h00
`define TC_RST_MASK         8'hff
`define TC_RST_BUS          10'h000

// Palette pipeline latency in pixel clocks
`define TC_PIPE_LAT         4

`endif

//--- core/test_capture_pkg.sv
// Types shared by the test capture block
package test_capture_pkg;

    // Read slot within a multi-cycle test register read
    typedef enum logic [2:0] {
        SLOT_0,
        SLOT_1,
        SLOT_2,
        SLOT_3,
        SLOT_4,
        SLOT_5
    } slot_t;

endpackage

//--- core/red_msb_edge_detect.sv
// Edge detector on the red trigger bit with selectable polarity
`timescale 1ns/1ps
module red_msb_edge_detect (
    input  logic clk_sys,
    input  logic srst,
    input  logic red_msb_trigger,
    input  logic rising_sel,
    output logic edge_hit
);

    logic prev_q;

    // Previous pixel's trigger bit; follows the pin in reset as well,
    // so the first pixel after reset never shows a false edge
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prev_q <= red_msb_trigger;
        end else begin
            prev_q <= red_msb_trigger;
        end
    end

    // Combinational so the pixel carrying the edge itself is caught
    always_comb begin
        if (rising_sel) begin
            edge_hit = red_msb_trigger & ~prev_q;
        end else begin
            edge_hit = ~red_msb_trigger & prev_q;
        end
    end

endmodule

//--- core/capture_strobe_delay.sv
// Fixed delay line carrying the capture strobe down the pipeline
`timescale 1ns/1ps
module capture_strobe_delay #(
    parameter int DEPTH = 4
) (
    input  logic clk_sys,
    input  logic srst,
    input  logic strobe_in,
    output logic strobe_out
);

    logic [DEPTH-1:0] shift_q;

    if (DEPTH < 1) begin : g_depth_check
        $error("capture_strobe_delay: DEPTH must be at least 1");
    end

    // One stage per pipeline clock, no bubbles
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            shift_q <= '0;
        end else begin
            shift_q <= DEPTH'({shift_q, strobe_in}); // Oldest bit drops off
        end
    end

    assign strobe_out = shift_q[DEPTH-1];

endmodule

//--- core/pixel_pipeline_test_capture.sv
// Host register port and pixel pipeline test capture registers
`timescale 1ns/1ps
`include "test_capture_map.svh"
module pixel_pipeline_test_capture
    import test_capture_pkg::*;
#(
    parameter int PIPE_LAT = `TC_PIPE_LAT
) (
    input  logic                  clk_sys,
    input  logic                  srst,
    input  logic                  host_access,
    input  logic                  ctrl_select_hi,
    input  logic                  ctrl_select_lo,
    input  logic                  host_read,
    input  logic [`TC_BUS_W-1:0]  host_data_in,
    output logic [`TC_BUS_W-1:0]  host_data_out_q,
    output logic                  host_data_oe_q,
    input  logic [7:0]            pix_red,
    input  logic [7:0]            pix_green,
    input  logic [7:0]            pix_blue,
    input  logic [9:0]            conv_red,
    input  logic [9:0]            conv_green,
    input  logic [9:0]            conv_blue,
    input  logic                  sync_n,
    input  logic                  blank_n,
    input  logic                  pll_current_out,
    output logic [`TC_REG_W-1:0]  pixel_mask_q,
    output logic [`TC_REG_W-1:0]  command_two_q,
    output logic [`TC_REG_W-1:0]  command_three_q
);

    if (PIPE_LAT < 1) begin : g_lat_check
        $error("pixel_pipeline_test_capture: PIPE_LAT must be >= 1");
    end

    // Address pointer and access decode
    logic [`TC_PTR_W-1:0] ptr_q;
    logic                 acc_ptr;
    logic                 acc_reg;
    logic                 wr_ptr;
    logic                 wr_reg;
    logic                 rd_ptr;
    logic                 rd_reg;

    // Capture state
    logic        in_hit;
    logic        out_hit;
    logic [23:0] in_cap_q;
    logic [29:0] out_cap_q;
    logic [7:0]  status_cap_q;
    logic [23:0] in_shadow_q;
    logic [29:0] out_shadow_q;
    slot_t       in_slot_q;
    slot_t       out_slot_q;

    // Read path
    logic [`TC_BUS_W-1:0] rd_data_d;
    logic                 res8;
    logic                 bus8;
    logic                 out_last;

    // Pick one 10-bit colour from a packed red-green-blue word
    // Index 3 never occurs; it reads as zero rather than wrapping
    function automatic logic [9:0] pick_comp(
        input logic [29:0] word,
        input logic [1:0]  idx
    );
        logic [9:0] comp;
        comp = 10'h000;
        case (idx)
            2'd0: comp = word[29:20];
            2'd1: comp = word[19:10];
            2'd2: comp = word[9:0];
            default: comp = 10'h000;
        endcase
        return comp;
    endfunction

    // Step a read slot, wrapping after the last slot of the group
    function automatic slot_t next_slot(
        input slot_t cur,
        input logic  last
    );
        slot_t nxt;
        nxt = SLOT_0;
        if (!last) begin
            case (cur)
                SLOT_0: nxt = SLOT_1;
                SLOT_1: nxt = SLOT_2;
                SLOT_2: nxt = SLOT_3;
                SLOT_3: nxt = SLOT_4;
                SLOT_4: nxt = SLOT_5;
                default: nxt = SLOT_0;
            endcase
        end
        return nxt;
    endfunction

    // Both select lines low reach the pointer; hi only reaches registers
    assign acc_ptr = host_access & ~ctrl_select_hi & ~ctrl_select_lo;
    assign acc_reg = host_access & ctrl_select_hi & ~ctrl_select_lo;
    assign wr_ptr  = acc_ptr & ~host_read;
    assign rd_ptr  = acc_ptr & host_read;
    assign wr_reg  = acc_reg & ~host_read;
    assign rd_reg  = acc_reg & host_read;

    // Mode bits steering the capture and read paths
    assign res8 = command_two_q[`TC_RES8_BIT];
    assign bus8 = command_three_q[`TC_BUS8_BIT];

    // Address pointer, loaded by a control write
    // Data accesses never step it, so a register can be read again
    // and again without being reselected
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ptr_q <= `TC_RST_PTR;
        end else if (wr_ptr) begin
            ptr_q <= host_data_in[`TC_PTR_W-1:0];
        end
    end

    // Command and mask registers; pointer is left alone on data access
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pixel_mask_q    <= `TC_RST_MASK;
            command_two_q   <= `TC_RST_REG;
            command_three_q <= `TC_RST_REG;
        end else if (wr_reg) begin
            case (ptr_q)
                `TC_OFS_PIXEL_MASK: begin
                    pixel_mask_q <= host_data_in[`TC_REG_W-1:0];
                end
                `TC_OFS_CMD_TWO: begin
                    command_two_q <= host_data_in[`TC_REG_W-1:0];
                end
                `TC_OFS_CMD_THREE: begin
                    command_three_q <= host_data_in[`TC_REG_W-1:0];
                end
                default: begin
                    // Test registers are read-only; writes dropped
                end
            endcase
        end
    end

    // Trigger detection on the incoming pixel stream
    // The detector follows the pin during reset, so no false edge
    red_msb_edge_detect u_edge (
        .clk_sys         (clk_sys),
        .srst            (srst),
        .red_msb_trigger (pix_red[7]),
        .rising_sel      (command_two_q[`TC_EDGE_SEL_BIT]),
        .edge_hit        (in_hit)
    );

    // Strobe follows the pixel through the palette pipeline
    // A depth off by one would pair a pixel with its neighbour's output
    capture_strobe_delay #(
        .DEPTH (PIPE_LAT)
    ) u_delay (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .strobe_in  (in_hit),
        .strobe_out (out_hit)
    );

    // Input-side capture of the triggering pixel itself
    // The hit is combinational, so the edge pixel is taken, not the next
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            in_cap_q <= 24'h000000;
        end else if (in_hit) begin
            in_cap_q <= {pix_red, pix_green, pix_blue};
        end
    end
    // Without a hit the value holds

    // Output-side capture, blank and resolution masking applied
    // Blank wins over resolution: a blanked pixel reads black either way
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            out_cap_q <= 30'h00000000;
        end else if (out_hit) begin
            if (!blank_n) begin
                out_cap_q <= 30'h00000000;
            end else if (res8) begin
                out_cap_q <= {2'b00, conv_red[7:0],
                              2'b00, conv_green[7:0],
                              2'b00, conv_blue[7:0]};
            end else begin
                out_cap_q <= {conv_red, conv_green, conv_blue};
            end
        end
    end

    // Status byte taken on the same strobe as the output capture
    // Sync and blank are stored at pin level, so they read active low
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            status_cap_q <= 8'h00;
        end else if (out_hit) begin
            status_cap_q <= 8'h00;
            status_cap_q[`TC_STAT_SYNC_BIT]  <= sync_n;
            status_cap_q[`TC_STAT_BLANK_BIT] <= blank_n;
            status_cap_q[`TC_STAT_PLL_BIT]   <= pll_current_out;
        end
    end

    // Last slot of an output capture read group
    // Six slots on the 8-bit bus, three on the 10-bit bus
    assign out_last = bus8 ? (out_slot_q == SLOT_5)
                           : (out_slot_q == SLOT_2);

    // Read slots restart whenever the pointer is rewritten
    // Reading the pointer leaves a half-read group where it stood
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            in_slot_q  <= SLOT_0;
            out_slot_q <= SLOT_0;
        end else if (wr_ptr) begin
            in_slot_q  <= SLOT_0;
            out_slot_q <= SLOT_0;
        end else if (rd_reg) begin
            if (ptr_q == `TC_OFS_IN_CAP) begin
                in_slot_q <= next_slot(in_slot_q,
                                       in_slot_q == SLOT_2);
            end
            if (ptr_q == `TC_OFS_OUT_CAP) begin
                out_slot_q <= next_slot(out_slot_q, out_last);
            end
        end
    end

    // Freeze a whole sample when the first part is read, so a new
    // trigger mid-group cannot mix two pixels in one readout
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            in_shadow_q  <= 24'h000000;
            out_shadow_q <= 30'h00000000;
        end else if (rd_reg) begin
            if (ptr_q == `TC_OFS_IN_CAP && in_slot_q == SLOT_0) begin
                in_shadow_q <= in_cap_q;
            end
            if (ptr_q == `TC_OFS_OUT_CAP && out_slot_q == SLOT_0) begin
                out_shadow_q <= out_cap_q;
            end
        end
    end

    // Read data selection; narrow registers sit in the low bits
    // The input and output captures read through slots; a pointer write restarts them
    always_comb begin
        logic [23:0] in_src;
        logic [29:0] out_src;
        logic [9:0]  comp;
        logic [2:0]  oidx;
        in_src    = (in_slot_q == SLOT_0) ? in_cap_q : in_shadow_q;
        out_src   = (out_slot_q == SLOT_0) ? out_cap_q : out_shadow_q;
        oidx      = 3'(out_slot_q);
        comp      = 10'h000;
        rd_data_d = `TC_RST_BUS;
        if (rd_ptr) begin
            rd_data_d = {2'b00, ptr_q};
        end else if (rd_reg) begin
            case (ptr_q)
                `TC_OFS_PIXEL_MASK: begin
                    rd_data_d = {2'b00, pixel_mask_q};
                end
                `TC_OFS_CMD_TWO: begin
                    rd_data_d = {2'b00, command_two_q};
                end
                `TC_OFS_CMD_THREE: begin
                    rd_data_d = {2'b00, command_three_q};
                end
                `TC_OFS_IN_CAP: begin
                    case (in_slot_q)
                        SLOT_0: rd_data_d = {2'b00, in_src[23:16]};
                        SLOT_1: rd_data_d = {2'b00, in_src[15:8]};
                        default: rd_data_d = {2'b00, in_src[7:0]};
                    endcase
                end
                `TC_OFS_OUT_CAP: begin
                    if (bus8) begin
                        // Low byte then upper two bits per colour
                        comp = pick_comp(out_src, oidx[2:1]);
                        if (oidx[0]) begin
                            rd_data_d = {8'h00, comp[9:8]};
                        end else begin
                            rd_data_d = {2'b00, comp[7:0]};
                        end
                    end else begin
                        rd_data_d = pick_comp(out_src, oidx[1:0]);
                    end
                end
                `TC_OFS_STATUS_CAP: begin
                    rd_data_d = {2'b00, status_cap_q};
                end
                default: begin
                    rd_data_d = `TC_RST_BUS;
                end
            endcase
        end
    end

    // Read answer registered; bus driven for one cycle per read
    // Lo-select cycles belong to other address spaces; they get no
    // drive enable and leave the last read data standing
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            host_data_out_q <= `TC_RST_BUS;
            host_data_oe_q  <= 1'b0;
        end else begin
            host_data_oe_q <= rd_ptr | rd_reg;
            if (rd_ptr | rd_reg) begin
                host_data_out_q <= rd_data_d;
            end
        end
    end

endmodule

//--- tb/test_capture_checker.sv
// Concurrent checks on the host register port of the test capture block
`timescale 1ns/1ps
`include "test_capture_map.svh"
module test_capture_checker #(
    parameter int PIPE_LAT = 4
) (
    input logic                 clk_sys,
    input logic                 srst,
    input logic                 host_access,
    input logic                 ctrl_select_hi,
    input logic                 ctrl_select_lo,
    input logic                 host_read,
    input logic [`TC_BUS_W-1:0] host_data_in,
    input logic [`TC_BUS_W-1:0] host_data_out_q,
    input logic                 host_data_oe_q,
    input logic [`TC_REG_W-1:0] command_two_q,
    input logic [`TC_REG_W-1:0] command_three_q
);
    logic [7:0] ptr_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    // Shadow pointer, since the real one is not visible at the ports
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ptr_q <= `TC_RST_PTR;
        end else if (host_access && !ctrl_select_hi && !ctrl_select_lo
                     && !host_read) begin
            ptr_q <= host_data_in[7:0];
        end
    end

    // Data access at a given pointer, and a pointer access
    sequence s_data(logic [7:0] o, logic rd);
        host_access && ctrl_select_hi && !ctrl_select_lo
            && host_read == rd && ptr_q == o;
    endsequence
    sequence s_ptr(logic rd);
        host_access && !ctrl_select_hi && !ctrl_select_lo && host_read == rd;
    endsequence

    chk_read_answers: assert property (
        host_access && host_read && !ctrl_select_lo |=> host_data_oe_q)
        else $error("read without drive enable");
    chk_oe_one_shot: assert property (
        !(host_access && host_read && !ctrl_select_lo) |=> !host_data_oe_q)
        else $error("drive enable without read");
    chk_cmd_untouched: assert property (
        host_access && (ctrl_select_lo || !ctrl_select_hi) |=>
        $stable(command_two_q) && $stable(command_three_q))
        else $error("command register moved without a write");
    chk_data_holds: assert property (
        !host_data_oe_q && !$past(srst) |-> $stable(host_data_out_q))
        else $error("read data moved between reads");
    chk_cmd_two_load: assert property (
        s_data(8'h06, 1'b0) |=>
        {2'b00, command_two_q} == ($past(host_data_in) & 10'h0ff))
        else $error("command two not loaded");
    chk_cmd_three_load: assert property (
        s_data(8'h07, 1'b0) |=>
        {2'b00, command_three_q} == ($past(host_data_in) & 10'h0ff))
        else $error("command three not loaded");
    chk_cmd_readback: assert property (
        s_data(8'h06, 1'b1) |=>
        host_data_out_q == {2'b00, $past(command_two_q)})
        else $error("command two readback wrong");
    chk_ptr_readback: assert property (
        s_ptr(1'b1) |=> host_data_out_q == {2'b00, $past(ptr_q)})
        else $error("pointer readback wrong");
    chk_unmapped_zero: assert property (
        host_access && host_read && ctrl_select_hi && !ctrl_select_lo
        && (ptr_q < 8'h04 || ptr_q > 8'h09) |=> host_data_out_q == 10'h000)
        else $error("unmapped read not zero");
    chk_status_upper: assert property (
        s_data(8'h09, 1'b1) |=> host_data_out_q[9:3] == 7'h00)
        else $error("status upper bits not zero");
endmodule

bind pixel_pipeline_test_capture test_capture_checker #(
    .PIPE_LAT(PIPE_LAT)
) u_test_capture_checker (.clk_sys, .srst, .host_access, .ctrl_select_hi,
    .ctrl_select_lo, .host_read, .host_data_in, .host_data_out_q,
    .host_data_oe_q, .command_two_q, .command_three_q);

//--- tb/host_port_model.sv
// Host processor model issuing single port cycles
`timescale 1ns/1ps
`include "test_capture_map.svh"
module host_port_model (
    input  logic                 clk_sys,
    output logic                 host_access,
    output logic                 ctrl_select_hi,
    output logic                 ctrl_select_lo,
    output logic                 host_read,
    output logic [`TC_BUS_W-1:0] host_data_in,
    input  logic [`TC_BUS_W-1:0] host_data_out_q,
    input  logic                 host_data_oe_q
);
    // Idle port at time zero
    initial begin
        host_access = 1'b0;
        {ctrl_select_hi, ctrl_select_lo, host_read} = 3'b000;
        host_data_in = `TC_RST_BUS;
    end

    // One cycle; released lines flip so stale values cannot pass
    task automatic acc(input logic hi, input logic lo, input logic rd,
                       input logic [9:0] d, output logic [9:0] q,
                       output logic ok);
        @(posedge clk_sys);
        #1;
        host_access = 1'b1;
        {ctrl_select_hi, ctrl_select_lo, host_read} = {hi, lo, rd};
        host_data_in = d;
        @(posedge clk_sys);
        #1;
        host_access = 1'b0;
        {ctrl_select_hi, ctrl_select_lo, host_read} = ~{hi, lo, rd};
        host_data_in = ~d;
        ok = 1'b1;
        q = 10'h000;
        // The answer stands only until the next edge, so take it now
        if (rd) begin
            ok = host_data_oe_q;
            q = host_data_out_q;
        end
    endtask
endmodule

//--- tb/testbench.sv
// Self-checking bench for the pixel pipeline test capture block
`timescale 1ns/1ps
`include "test_capture_map.svh"
`define CMP(a, b, m) begin \
    checks_done++; \
    if ((a) !== (b)) begin \
        n_errors++; \
        $display("CHECK FAILED %0t %s", $time, m); \
    end \
end
module testbench;
    localparam int LAT = 3;
    logic        clk_sys, srst, host_access, ctrl_select_hi, ctrl_select_lo;
    logic        host_read, host_data_oe_q, sync_n, blank_n, pll_current_out;
    logic        ok;
    logic [9:0]  host_data_in, host_data_out_q, conv_red, conv_green;
    logic [9:0]  conv_blue, q, d;
    logic [7:0]  pix_red, pix_green, pix_blue, pixel_mask_q, a;
    logic [7:0]  command_two_q, command_three_q;
    logic [23:0] exp_in;
    logic [29:0] exp_out;
    logic [2:0]  exp_st;
    int          n_errors, checks_done, seed;

    pixel_pipeline_test_capture #(
        .PIPE_LAT (LAT)
    ) u_pixel_pipeline_test_capture (
        .clk_sys, .srst, .host_access, .ctrl_select_hi, .ctrl_select_lo,
        .host_read, .host_data_in, .host_data_out_q, .host_data_oe_q,
        .pix_red, .pix_green, .pix_blue, .conv_red, .conv_green, .conv_blue,
        .sync_n, .blank_n, .pll_current_out, .pixel_mask_q, .command_two_q,
        .command_three_q);
    host_port_model u_host_port_model (.clk_sys, .host_access,
        .ctrl_select_hi, .ctrl_select_lo, .host_read, .host_data_in,
        .host_data_out_q, .host_data_oe_q);

    // Clock at 40 MHz
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // One pixel clock; trigger bit and blank given by the caller
    task automatic px(input logic t, input logic b);
        @(posedge clk_sys);
        #1;
        {pix_red, pix_green, pix_blue} = 24'($random(seed));
        pix_red[7] = t;
        {conv_red, conv_green, conv_blue} = 30'($random(seed));
        {sync_n, pll_current_out} = 2'($random(seed));
        blank_n = b;
    endtask

    // Expected output capture from the pipeline output now driven
    function automatic logic [29:0] conv_exp(input logic r8);
        if (!blank_n) return 30'h0;
        if (r8) return {conv_red & 10'h0ff, conv_green & 10'h0ff,
                        conv_blue & 10'h0ff};
        return {conv_red, conv_green, conv_blue};
    endfunction

    // Expected value of read slot k of the output capture
    function automatic logic [9:0] slot(input logic [29:0] c,
                                        input logic b8, input int k);
        logic [9:0] w;
        w = c[29 - 10 * (b8 ? k / 2 : k) -: 10];
        if (!b8) return w;
        return k[0] ? {8'h00, w[9:8]} : {2'b00, w[7:0]};
    endfunction

    // Port cycle wrappers
    task automatic sel(input logic [7:0] p);
        u_host_port_model.acc(1'b0, 1'b0, 1'b0, {2'b00, p}, q, ok);
    endtask
    task automatic wr(input logic [9:0] v);
        u_host_port_model.acc(1'b1, 1'b0, 1'b0, v, q, ok);
    endtask
    task automatic rd(input logic [9:0] e);
        u_host_port_model.acc(1'b1, 1'b0, 1'b1, 10'h000, q, ok);
        `CMP(ok, 1'b1, "drive enable missing")
        `CMP(q, e, "read data mismatch")
    endtask

    task automatic print_verdict;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        #1000000;
        n_errors++;
        print_verdict;
    end

    // Main sequence: register port first, then capture in every mode
    initial begin
        seed = 32'h5213baeb;
        srst = 1'b1;
        {pix_red, pix_green, pix_blue} = 24'h0;
        {conv_red, conv_green, conv_blue} = 30'h0;
        {sync_n, blank_n, pll_current_out} = 3'b111;
        repeat (4) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        sel(8'h04);
        rd(10'h0ff);
        `CMP(pixel_mask_q, 8'hff, "mask reset")
        wr(10'h05a);
        `CMP(pixel_mask_q, 8'h5a, "mask write")
        rd(10'h05a);
        sel(8'h05);
        wr(10'h3ff);
        sel(8'h05);
        rd(10'h000);
        sel(8'h06);
        wr(10'h0e0);
        rd(10'h0e0);
        sel(8'h07);
        wr(10'h040);
        rd(10'h040);
        sel(8'h06);
        rd(10'h0e0);
        sel(8'h07);
        rd(10'h040);
        // Lo-select cycles are not for this block: no answer, no write
        u_host_port_model.acc(1'b1, 1'b1, 1'b0, 10'h3ff, q, ok);
        u_host_port_model.acc(1'b1, 1'b1, 1'b1, 10'h000, q, ok);
        `CMP(ok, 1'b0, "lo select answered")
        `CMP(command_three_q, 8'h40, "lo select wrote")
        u_host_port_model.acc(1'b0, 1'b0, 1'b1, 10'h000, q, ok);
        `CMP(q, 10'h007, "pointer readback")
        sel(8'h2a);
        rd(10'h000);
        repeat (6) begin
            a = 8'h06 + 8'($random(seed) & 1);
            d = 10'($random(seed));
            sel(a);
            wr(d);
            q = a[0] ? {2'b00, command_three_q} : {2'b00, command_two_q};
            `CMP(q, {2'b00, d[7:0]}, "port")
            rd({2'b00, d[7:0]});
        end
        // Bit 0 edge select, bit 1 resolution, bit 2 bus width
        for (int i = 0; i < 8; i++) begin
            sel(8'h06);
            wr({8'h00, i[1], i[0]});
            sel(8'h07);
            wr({8'h00, i[2], 1'b0});
            px(~i[0], 1'b1);
            px(~i[0], 1'b1);
            px(i[0], 1'b1);
            exp_in = {pix_red, pix_green, pix_blue};
            repeat (LAT - 1) px(i[0], 1'($random(seed)));
            px(i[0], !(i == 2 || i == 5));
            exp_out = conv_exp(i[1]);
            exp_st = {pll_current_out, blank_n, sync_n};
            // Opposite edge and idle pixels must not disturb the captures
            repeat (3) px(~i[0], 1'($random(seed)));
            sel(8'h05);
            for (int k = 0; k < 3; k++) begin
                rd({2'b00, exp_in[23 - 8 * k -: 8]});
            end
            sel(8'h08);
            for (int k = 0; k < (i[2] ? 6 : 3); k++) begin
                rd(slot(exp_out, i[2], k));
            end
            sel(8'h09);
            u_host_port_model.acc(1'b1, 1'b0, 1'b1, 10'h000, q, ok);
            `CMP(q[2:0], exp_st, "status capture")
        end
        print_verdict;
    end
endmodule
